// file: pbs_cpu_model.sv
// pbs_cpu_model: processor stand-in that takes over the power rails.
// assumes reset_pin is the resolved open-drain level with a pull-up.
`timescale 1ns/100ps
module pbs_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // scenario controls
    input wire logic reset_pin,
    input wire logic hold,
    input wire logic [3:0] dly,
    input wire logic [1:0] sel,
    // rail enable inputs
    output logic [2:0] en
);
    logic [3:0] cnt;

    // ****************
    // take-over
    // ****************
    // extra delay lengthens the hold the user must give the button
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            en <= 3'h0;
        end else if (!hold) begin
            cnt <= 4'h0;
            en <= 3'h0;
        end else if (reset_pin && cnt < dly) begin
            cnt <= cnt + 4'h1;
        end else if (reset_pin) begin
            en[sel] <= 1'b1;
        end
    end
endmodule

// file: pbs_pkg.sv
// pbs_pkg: constants and types for the push-button power-up sequencer.
// assumes a 10 MHz clk; all analog results arrive as synchronous levels.
package pbs_pkg;

    // ********************************
    // timebase
    // ********************************
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned RESET_PERIOD_MS = 260;
    localparam int unsigned TICK_MS = 1;
    // one millisecond tick from the divider
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RESET_TICKS = RESET_PERIOD_MS / TICK_MS;
    localparam int TICK_W = 14;
    localparam int RST_W = 9;

    // ********************************
    // sequence variants and states
    // ********************************
    typedef enum logic [2:0] {
        PBS_VAR_A,
        PBS_VAR_B,
        PBS_VAR_C,
        PBS_VAR_D,
        PBS_VAR_E
    } pbs_variant_t;

    typedef enum logic [2:0] {
        PBS_IDLE,
        PBS_RAMP,
        PBS_RESET,
        PBS_WAIT_WIN,
        PBS_HANDOFF,
        PBS_RUN
    } pbs_state_t;

    // rail vector bit positions
    localparam int RAIL_B1 = 0;
    localparam int RAIL_B2 = 1;
    localparam int RAIL_B3 = 2;
    localparam int RAIL_L1 = 3;
    localparam int RAIL_L2 = 4;
    localparam int NRAIL = 5;

    localparam logic [4:0] RAILS_OFF = 5'h00;
    localparam logic [2:0] VARIANT_RST = 3'h1;

endpackage

// file: pbs_seq_assertions.sv
// pbs_seq_assertions: port-level timing checks for pbs_sequencer.
// assumes one clock domain; bound onto every sequencer instance.
`timescale 1ns/100ps
module pbs_seq_chk
    import pbs_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned RESET_MS = RESET_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // strap, start, enable and power-good inputs
    input wire logic [2:0] variant_strap,
    input wire logic push_button_n,
    input wire logic push_button_hard_n,
    input wire logic charger_input,
    input wire logic rail_enable_in_1,
    input wire logic rail_enable_in_2,
    input wire logic rail_enable_in_3,
    input wire logic first_rail_good,
    // sequencer outputs
    input wire logic buck_rail_first,
    input wire logic buck_rail_second,
    input wire logic buck_rail_third,
    input wire logic ldo_rail_first,
    input wire logic ldo_rail_second,
    input wire logic processor_reset_out_n_oe,
    input wire logic [2:0] seq_state
);
    localparam int unsigned LO = RESET_MS * TICK_DIV;
    wire logic [4:0] r = {ldo_rail_second, ldo_rail_first,
        buck_rail_third, buck_rail_second, buck_rail_first};
    wire logic [2:0] v = variant_strap;
    wire logic oe = processor_reset_out_n_oe;
    wire logic any_en = rail_enable_in_1 | rail_enable_in_2 | rail_enable_in_3;
    wire logic pg = seq_state == 3'h1 && first_rail_good && !push_button_n;
    // wide enough for the default period of millions of cycles
    logic [31:0] hi_q;

    // ****************
    // helper counter
    // ****************
    // cycles reset has stood; a hard press restarts the period, so clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            hi_q <= 32'h00000000;
        else if (!oe || !push_button_hard_n)
            hi_q <= 32'h00000000;
        else
            hi_q <= hi_q + 32'h00000001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    start_a: assert property (
        seq_state == 3'h0 && !push_button_n && $past(resetn)
        |=> buck_rail_first && r[4:1] == 4'h0)
        else $error("press not taken");
    var_b_a: assert property (
        pg && v == 3'h1 |=> r == 5'h07 && oe)
        else $error("variant B rails wrong at good");
    var_ce_a: assert property (
        pg && (v == 3'h2 || v == 3'h4) |=> r == 5'h1F && oe)
        else $error("variant C or E rails wrong at good");
    var_d_a: assert property (
        pg && v == 3'h3 |=> r == 5'h1B && oe)
        else $error("variant D rails wrong at good");
    var_a_a: assert property (
        pg && v == 3'h0 |=> r == 5'h19 && oe)
        else $error("variant A rails wrong at good");
    hold_time_a: assert property (
        $fell(oe) && seq_state == 3'h4 && $past(seq_state) == 3'h2
        |-> hi_q >= LO && hi_q <= LO + TICK_DIV + 1)
        else $error("reset period length wrong");
    abort_a: assert property (
        seq_state inside {[3'h1:3'h4]} && push_button_n && push_button_hard_n
        && !charger_input && !any_en |=> r == 5'h00 && !oe && seq_state == 3'h0)
        else $error("no shutdown on release");
    run_off_a: assert property (
        seq_state == 3'h5 && !any_en |=> seq_state == 3'h0 && r == 5'h00)
        else $error("run kept without enables");
    hard_a: assert property (
        !push_button_hard_n && seq_state != 3'h0 |=> oe)
        else $error("hard press left reset free");
endmodule

bind pbs_sequencer pbs_seq_chk #(.TICK_DIV(TICK_DIV), .RESET_MS(RESET_MS))
    u_chk (.clk, .resetn, .variant_strap, .push_button_n,
    .push_button_hard_n, .charger_input, .rail_enable_in_1,
    .rail_enable_in_2, .rail_enable_in_3, .first_rail_good,
    .buck_rail_first, .buck_rail_second, .buck_rail_third,
    .ldo_rail_first, .ldo_rail_second, .processor_reset_out_n_oe,
    .seq_state);

// file: pbs_sequencer.sv
// pbs_sequencer: top of the push-button power-up sequencer.
// assumes power-good, window, button and charger levels are synchronous.
`timescale 1ns/100ps
module pbs_sequencer
    import pbs_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned RESET_MS = RESET_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // factory variant strap
    input wire logic [2:0] variant_strap,
    // start sources
    input wire logic push_button_n,
    input wire logic push_button_hard_n,
    input wire logic charger_input,
    // processor enable inputs
    input wire logic rail_enable_in_1,
    input wire logic rail_enable_in_2,
    input wire logic rail_enable_in_3,
    // analog results
    input wire logic first_rail_good,
    input wire logic first_rail_output_in_window,
    // software rail enable bits
    input wire logic buck_first_enable_bit,
    input wire logic buck_second_enable_bit,
    input wire logic buck_third_enable_bit,
    input wire logic ldo_first_enable_bit,
    input wire logic ldo_second_enable_bit,
    // rail enables
    output logic buck_rail_first,
    output logic buck_rail_second,
    output logic buck_rail_third,
    output logic ldo_rail_first,
    output logic ldo_rail_second,
    // processor reset, open drain
    output logic processor_reset_out_n_o,
    output logic processor_reset_out_n_oe,
    // status
    output logic powered_up,
    output logic [2:0] seq_state
);

    // ********************************
    // state
    // ********************************
    // start_rst is not held here: the timer wants it on the same edge
    typedef struct packed {
        pbs_state_t st;
        pbs_variant_t var_sel;
        logic strap_taken;
        logic [NRAIL-1:0] rails;
        logic rst_asserted;
        logic hard_hold;
        logic by_charger;
    } pbs_seq_t;

    pbs_seq_t s_q, s_d;
    pbs_time_if tb ();

    logic any_en;
    logic soft_press;
    logic hard_press;
    logic [NRAIL-1:0] sw_bits;
    // timer restart request, combinational so the period begins at the
    // very edge that raises reset, not one cycle later
    logic start_rst;

    // a zero-length period would free reset before the rails settle
    if (RESET_MS < 1) begin : g_bad_reset_ms
        $error("pbs_sequencer: RESET_MS must be >= 1");
    end

    // the divider cannot serve a zero or over-wide division
    if (TICK_DIV < 1 || TICK_DIV > (1 << TICK_W)) begin : g_bad_tick_div
        $error("pbs_sequencer: TICK_DIV out of range");
    end

    pbs_tick_div #(
        .DIV(TICK_DIV)
    ) u_div (
        .clk(clk),
        .resetn(resetn),
        .tb(tb)
    );

    pbs_reset_timer #(
        .TICKS(RESET_MS)
    ) u_rtimer (
        .clk(clk),
        .resetn(resetn),
        .tb(tb)
    );

    // ********************************
    // input decode
    // ********************************
    // a hard press also counts as a press, so it can start from idle
    assign any_en = rail_enable_in_1 | rail_enable_in_2 | rail_enable_in_3;
    assign hard_press = !push_button_hard_n;
    assign soft_press = !push_button_n || hard_press;
    assign sw_bits = {ldo_second_enable_bit, ldo_first_enable_bit,
                      buck_third_enable_bit, buck_second_enable_bit,
                      buck_first_enable_bit};
    assign tb.rst_start = start_rst;

    // rails that turn on at first-rail power-good, per variant
    // variant B ldos are cleared later, so they stay off until run
    function automatic logic [NRAIL-1:0] pg_rails(pbs_variant_t v);
        logic [NRAIL-1:0] r;
        r = '0;
        r[RAIL_B1] = 1'b1;
        unique case (v)
            PBS_VAR_A: begin
                r[RAIL_L1] = 1'b1;
                r[RAIL_L2] = 1'b1;
            end
            PBS_VAR_B: begin
                r[RAIL_B2] = 1'b1;
                r[RAIL_B3] = 1'b1;
            end
            PBS_VAR_C, PBS_VAR_E: begin
                r = '1;
            end
            PBS_VAR_D: begin
                r[RAIL_B2] = 1'b1;
                r[RAIL_L1] = 1'b1;
                r[RAIL_L2] = 1'b1;
            end
            default: r = r;
        endcase
        return r;
    endfunction

    // ********************************
    // sequencing
    // ********************************
    // flow: idle -> ramp on a start source; ramp -> reset at first-rail
    // good, with the variant's rails; reset -> handoff when the period
    // ends (outside variant D only with the first rail in window), else
    // wait-window; handoff -> run on any enable input; run -> idle when
    // all enables drop. releasing the start source before run aborts.
    // one process holds the whole flow; the strap is caught once, after
    // reset release, so a floating strap during reset cannot leak in
    always_comb begin
        s_d = s_q;
        start_rst = 1'b0;
        if (!s_q.strap_taken) begin
            s_d.strap_taken = 1'b1;
            s_d.var_sel = pbs_variant_t'(variant_strap);
        end
        unique case (s_q.st)
            PBS_IDLE: begin
                // all off while idle; a stale timer end is harmless here
                s_d.rails = RAILS_OFF;
                s_d.rst_asserted = 1'b0;
                s_d.by_charger = 1'b0;
                if (s_q.strap_taken && soft_press) begin
                    s_d.st = PBS_RAMP;
                    s_d.rails[RAIL_B1] = 1'b1;
                end else if (s_q.strap_taken && charger_input
                             && s_q.var_sel == PBS_VAR_E) begin
                    s_d.st = PBS_RAMP;
                    s_d.by_charger = 1'b1;
                    s_d.rails[RAIL_B1] = 1'b1;
                end
            end
            PBS_RAMP: begin
                if (first_rail_good) begin
                    s_d.rails = pg_rails(s_q.var_sel);
                    s_d.rst_asserted = 1'b1;
                    // the timer restarts on this same edge
                    start_rst = 1'b1;
                    s_d.st = PBS_RESET;
                end
            end
            PBS_RESET, PBS_WAIT_WIN: begin
                if (tb.rst_done || s_q.st == PBS_WAIT_WIN) begin
                    if (s_q.var_sel == PBS_VAR_D
                        || first_rail_output_in_window) begin
                        s_d.rst_asserted = 1'b0;
                        s_d.st = PBS_HANDOFF;
                    end else begin
                        // out of window: reset stays down until it is in
                        s_d.st = PBS_WAIT_WIN;
                    end
                end
            end
            PBS_HANDOFF: begin
                // the processor claims the rails; the button may now go
                if (any_en) begin
                    s_d.st = PBS_RUN;
                    if (s_q.var_sel == PBS_VAR_D) begin
                        s_d.rails[RAIL_B3] = 1'b1;
                    end
                end
            end
            PBS_RUN: begin
                // software owns the rails it may switch; the rest hold
                unique case (s_q.var_sel)
                    PBS_VAR_D: s_d.rails = sw_bits;
                    PBS_VAR_B, PBS_VAR_C, PBS_VAR_E, PBS_VAR_A: begin
                        s_d.rails[RAIL_L1] = ldo_first_enable_bit;
                        s_d.rails[RAIL_L2] = ldo_second_enable_bit;
                    end
                    default: s_d.rails = s_d.rails;
                endcase
                if (!any_en) begin
                    s_d.st = PBS_IDLE;
                    s_d.rails = RAILS_OFF;
                end
            end
            default: s_d.st = PBS_IDLE;
        endcase
        // a period started by a hard release ends outside the reset
        // states; without this the reset line would stay down in run
        if (tb.rst_done && !(s_q.st inside {PBS_RESET, PBS_WAIT_WIN})) begin
            s_d.rst_asserted = 1'b0;
        end
        // hard press: immediate reset, re-armed period on release; it sits
        // after the flow so a period end cannot free reset while held
        if (hard_press && s_q.st != PBS_IDLE) begin
            s_d.rst_asserted = 1'b1;
            s_d.hard_hold = 1'b1;
        end else if (s_q.hard_hold) begin
            s_d.hard_hold = 1'b0;
            start_rst = 1'b1;
        end
        // early release of the start source before run aborts startup
        if (s_q.st inside {PBS_RAMP, PBS_RESET, PBS_WAIT_WIN, PBS_HANDOFF}
            && !(s_q.st == PBS_HANDOFF && any_en)) begin
            if ((!s_q.by_charger && !soft_press)
                || (s_q.by_charger && !charger_input)) begin
                s_d.st = PBS_IDLE;
                s_d.rails = RAILS_OFF;
                s_d.rst_asserted = 1'b0;
                s_d.hard_hold = 1'b0;
                // a timer left running here ends harmlessly in idle
                start_rst = 1'b0;
            end
        end
        // variant B ldos stay off until software sets their enable bits
        // in run; earlier stages must not power them by variant rails
        if (s_q.var_sel == PBS_VAR_B && s_d.st != PBS_RUN) begin
            s_d.rails[RAIL_L1] = 1'b0;
            s_d.rails[RAIL_L2] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{st: PBS_IDLE, var_sel: pbs_variant_t'(VARIANT_RST),
                     strap_taken: 1'b0, rails: RAILS_OFF,
                     rst_asserted: 1'b0, hard_hold: 1'b0,
                     by_charger: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // rail enables come straight from flops, so no glitch reaches a rail
    assign buck_rail_first = s_q.rails[RAIL_B1];
    assign buck_rail_second = s_q.rails[RAIL_B2];
    assign buck_rail_third = s_q.rails[RAIL_B3];
    assign ldo_rail_first = s_q.rails[RAIL_L1];
    assign ldo_rail_second = s_q.rails[RAIL_L2];
    // open drain: only ever pulls low
    assign processor_reset_out_n_o = 1'b0;
    assign processor_reset_out_n_oe = s_q.rst_asserted;
    // status for the processor side
    assign powered_up = (s_q.st == PBS_RUN);
    assign seq_state = s_q.st;

endmodule

// file: pbs_tb.sv
// tb: self-checking bench for the power-up sequencer, short timers.
// assumes the processor model claims a rail after reset is released.
`timescale 1ns/100ps
module tb;
    localparam int DV = 4;
    localparam int MS = 3;
    logic clk = 0, resetn = 0, pb_n = 1, hard_n = 1, chg = 0;
    logic pg = 0, win = 1, hold = 0;
    logic [2:0] v = 3'h1;
    logic [4:0] bits = 5'h00, m;
    logic [3:0] dly = 4'h0;
    logic [1:0] sel = 2'h0;
    logic [2:0] en, st;
    logic [4:0] rails;
    logic rst_o, rst_oe, up;
    logic [2:0] vs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    wire logic pin = rst_oe ? rst_o : 1'b1;  // pull-up on the reset line
    int n_mismatch = 0, comparisons = 0, cyc = 0, t;

    pbs_sequencer #(.TICK_DIV(DV), .RESET_MS(MS)) u_dut (
        .clk(clk), .resetn(resetn), .variant_strap(v),
        .push_button_n(pb_n), .push_button_hard_n(hard_n),
        .charger_input(chg), .rail_enable_in_1(en[0]),
        .rail_enable_in_2(en[1]), .rail_enable_in_3(en[2]),
        .first_rail_good(pg), .first_rail_output_in_window(win),
        .buck_first_enable_bit(bits[0]), .buck_second_enable_bit(bits[1]),
        .buck_third_enable_bit(bits[2]), .ldo_first_enable_bit(bits[3]),
        .ldo_second_enable_bit(bits[4]), .buck_rail_first(rails[0]),
        .buck_rail_second(rails[1]), .buck_rail_third(rails[2]),
        .ldo_rail_first(rails[3]), .ldo_rail_second(rails[4]),
        .processor_reset_out_n_o(rst_o),
        .processor_reset_out_n_oe(rst_oe), .powered_up(up), .seq_state(st));
    pbs_cpu_model u_cpu (.clk(clk), .resetn(resetn), .reset_pin(pin),
        .hold(hold), .dly(dly), .sel(sel), .en(en));

    always #50 clk = ~clk;

    // cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ****************
    // helpers
    // ****************
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(string n, logic [7:0] s, logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // inputs always move 10 ns after the edge
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic wait_st(logic [2:0] s);
        t = 0;
        while (st !== s && t < 60) begin
            step(1);
            t++;
        end
    endtask

    function automatic logic [4:0] exp_rails(logic [2:0] k);
        case (k)
            3'h0: return 5'h19;
            3'h1: return 5'h07;
            3'h3: return 5'h1B;
            default: return 5'h1F;
        endcase
    endfunction

    // strap only counts at reset, so each variant gets a fresh reset
    task automatic start(logic [2:0] k, logic by_chg);
        resetn = 0;
        hold = 0;
        v = k;
        pb_n = 1;
        chg = 0;
        pg = 0;
        win = 1;
        step(3);
        resetn = 1;
        step(2);
        if (by_chg)
            chg = 1;
        else
            pb_n = 0;
        step(1);
        check("first rail", rails, 5'h01);
        pg = 1;
        step(1);
        check("rails at good", rails, exp_rails(k));
        check("reset asserted", rst_oe, 1);
    endtask

    // ****************
    // scenarios
    // ****************
    initial begin
        void'($urandom(92));
        foreach (vs[i]) begin
            start(vs[i], 1'b0);
            wait_st(3'h4);
            t = int'(t >= DV * MS && t <= DV * MS + DV + 1);
            check("reset time", t, 1);
            check("reset pin", pin, 1);
            dly = 4'($urandom_range(9));
            sel = 2'($urandom_range(2));
            hold = 1;
            wait_st(3'h5);
            check("taken over", up, 1);
            if (vs[i] == 3'h3)
                check("third buck", rails[2], 1);
            pb_n = 1;
            bits = 5'($urandom);
            m = vs[i] == 3'h3 ? 5'h1F : 5'h18;
            step(2);
            check("kept on", up, 1);
            check("sw rails", rails & m, bits & m);
            if (vs[i] == 3'h4) begin
                hard_n = 0;
                step(3);
                check("hard reset", rst_oe, 1);
                hard_n = 1;
                step(2);
                check("hard reset held", rst_oe, 1);
                step(DV * MS + DV);
                check("hard reset end", rst_oe, 0);
            end else begin
                hold = 0;
                step(3);
                check("off rails", rails, 5'h00);
                check("off state", st, 3'h0);
            end
            $display("test variant %0d done", vs[i]);
        end
        start(3'h2, 1'b0);
        step(4);
        pb_n = 1;
        step(1);
        check("abort rails", rails, 5'h00);
        check("abort state", st, 3'h0);
        $display("test early release done");
        start(3'h1, 1'b0);
        win = 0;
        wait_st(3'h3);
        check("window wait", rst_oe, 1);
        win = 1;
        step(2);
        check("window release", rst_oe, 0);
        $display("test window done");
        start(3'h4, 1'b1);
        chg = 0;
        step(1);
        check("charger gone", rails, 5'h00);
        $display("test charger done");
        summarize();
    end
endmodule

// file: pbs_time_if.sv
// pbs_time_if: timebase signals shared by the sequencer and its timers.
// assumes one clock domain; the divider drives tick, the sequencer drives rst_start, the timer drives rst_done.
`timescale 1ns/100ps
interface pbs_time_if;
    logic tick;
    logic rst_start;
    logic rst_done;
    modport timer (input tick, input rst_start, output rst_done);
    modport div (output tick);
    modport seq (input tick, output rst_start, input rst_done);
endinterface

// file: pbs_timers.sv
// pbs_timers: millisecond divider and reset-period counter.
// assumes rst_start is high for one cycle per reset period request.
`timescale 1ns/100ps
module pbs_tick_div
    import pbs_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // timebase
    pbs_time_if.div tb
);
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } pbs_div_t;

    pbs_div_t s_q, s_d;

    // the counter cannot hold a division beyond its width
    if (DIV < 1 || DIV > (1 << TICK_W)) begin : g_bad_div
        $error("pbs_tick_div: bad DIV");
    end

    // free-running divider, one-cycle tick per period
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == TICK_W'(DIV - 1)) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tb.tick = s_q.tick;
endmodule

module pbs_reset_timer
    import pbs_pkg::*;
#(
    parameter int unsigned TICKS = RESET_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // timebase
    pbs_time_if.timer tb
);
    typedef struct packed {
        logic [RST_W-1:0] cnt;
        logic run;
        logic done;
    } pbs_rt_t;

    pbs_rt_t s_q, s_d;

    // the count must reach TICKS itself, so TICKS must fit the counter
    if (TICKS < 1 || TICKS >= (1 << RST_W)) begin : g_bad_ticks
        $error("pbs_reset_timer: bad TICKS");
    end

    // counts ticks; restart wins over a running count. the free divider
    // may tick right after a start, so one extra tick is counted: the
    // period is never short, and at most one tick longer
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (tb.rst_start) begin
            s_d.cnt = '0;
            s_d.run = 1'b1;
        end else if (s_q.run && tb.tick) begin
            if (s_q.cnt == RST_W'(TICKS)) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tb.rst_done = s_q.done;
endmodule
